// *** common/hlc_defs.svh ***
`ifndef HLC_DEFS_SVH
`define HLC_DEFS_SVH
// register offsets
`define HLC_OFS_CTRL1 4'h0
`define HLC_OFS_WMARK 4'h1
`define HLC_OFS_LIVE 4'h2
`define HLC_OFS_LATCH 4'h3
`define HLC_OFS_IEN 4'h4
`define HLC_OFS_TXDAT 4'h5
`define HLC_OFS_TXTAG 4'h6
`define HLC_OFS_RXDAT 4'h7
`define HLC_OFS_RXSTA 4'h8
// control one fields
`define HLC_B_CRC_DEF 0
`define HLC_B_CRC_INV 1
`define HLC_B_STF_DEF 2
`define HLC_B_FILL 3
`define HLC_B_TX_INV 4
`define HLC_B_RX_INV 5
`define HLC_B_TX_RST 6
`define HLC_B_RX_RST 7
// watermark fields and live status bits
`define HLC_B_TLM_LO 0
`define HLC_B_RHM_LO 4
`define HLC_B_LIVE_TLM 2
`define HLC_B_LIVE_RHM 3
// latched flag bits
`define HLC_L_TEND 0
`define HLC_L_TUDR 1
`define HLC_L_TX_LOW_MARK_LIVE 2
`define HLC_L_RX_HIGH_MARK_LIVE 3
`define HLC_L_RABT 4
`define HLC_L_RPS 5
`define HLC_L_RPE 6
`define HLC_L_ROVR 7
// reset values
`define HLC_RST_CTRL1 8'h00
`define HLC_RST_WMARK 8'h00
`define HLC_RST_IEN 8'h00
// line bytes and check sequence
`define HLC_FLAG 8'h7E
`define HLC_IDLE 8'hFF
`define HLC_ABORT 8'hFE
`define HLC_CRC_INIT 16'hFFFF
`define HLC_CRC_POLY 16'h8408
// fifo sizing and watermark step
`define HLC_FIFO_FULL 9'h100
`define HLC_WM_SHIFT 5
`define HLC_START_MIN 9'h002
`endif

// *** common/hlc_pkg.sv ***
package hlc_pkg;
  // transmit byte kind currently shifting out
  typedef enum logic [2:0] {
    TX_FILL = 3'b000,
    TX_ABORT = 3'b001,
    TX_OPEN = 3'b010,
    TX_DATA = 3'b011,
    TX_CRC_LO = 3'b100,
    TX_CRC_HI = 3'b101,
    TX_CLOSE = 3'b110,
    TX_CLOSE2 = 3'b111
  } hlc_tx_e;
  // receive framing state
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_FLAGGED = 2'b01,
    RX_PKT = 2'b10
  } hlc_rx_e;
  // transmit fifo entry
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } hlc_txent_s;
  // receive fifo entry
  typedef struct packed {
    logic last;
    logic first;
    logic [7:0] data;
  } hlc_rxent_s;
endpackage

// *** hw/hlc_ctrl.sv ***
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "hlc_defs.svh"
module hlc_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // block level interrupt enable and interrupt
  input wire logic link_block_irq_en,
  output logic irq,
  // serial transmit to overhead insertion
  input wire logic tx_bit_req,
  output logic tx_bit,
  // serial receive from overhead extraction
  input wire logic rx_bit_valid,
  input wire logic rx_bit
);
  // ==========================================
  // registers
  logic [7:0] ctrl1_ff, wmark_ff, ien_ff, latch_ff, txdat_ff, rdata_ff;
  logic tx_rst_old_ff, rx_rst_old_ff, tlm_old_ff, rhm_old_ff, irq_ff;
  logic wr_c1, wr_tag, wr_lat, rd_sta, tx_flush, rx_flush;
  logic tx_low, rx_high;
  logic [8:0] tx_thr, rx_thr;
  logic [7:0] lat_set, nxt_latch;
  assign wr_c1 = reg_wr && reg_addr == `HLC_OFS_CTRL1;
  assign wr_tag = reg_wr && reg_addr == `HLC_OFS_TXTAG;
  assign wr_lat = reg_wr && reg_addr == `HLC_OFS_LATCH;
  assign rd_sta = reg_rd && reg_addr == `HLC_OFS_RXSTA;
  assign tx_flush = ctrl1_ff[`HLC_B_TX_RST] && !tx_rst_old_ff;
  assign rx_flush = ctrl1_ff[`HLC_B_RX_RST] && !rx_rst_old_ff;

  // writable registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1_ff <= `HLC_RST_CTRL1;
      wmark_ff <= `HLC_RST_WMARK;
      ien_ff <= `HLC_RST_IEN;
      txdat_ff <= 8'h00;
    end else if (reg_wr) begin
      if (wr_c1) ctrl1_ff <= reg_wdata;
      if (reg_addr == `HLC_OFS_WMARK) wmark_ff <= reg_wdata;
      if (reg_addr == `HLC_OFS_IEN) ien_ff <= reg_wdata;
      if (reg_addr == `HLC_OFS_TXDAT) txdat_ff <= reg_wdata;
    end
  end

  // edge history for resets and live marks
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_rst_old_ff <= 1'b0;
      rx_rst_old_ff <= 1'b0;
      tlm_old_ff <= 1'b0;
      rhm_old_ff <= 1'b0;
    end else begin
      tx_rst_old_ff <= ctrl1_ff[`HLC_B_TX_RST];
      rx_rst_old_ff <= ctrl1_ff[`HLC_B_RX_RST];
      tlm_old_ff <= tx_low;
      rhm_old_ff <= rx_high;
    end
  end

  // ==========================================
  // transmit fifo
  hlc_pkg::hlc_txent_s tx_mem [0:255];
  hlc_pkg::hlc_txent_s tx_head;
  logic [7:0] tx_wp_ff, tx_rp_ff;
  logic [8:0] tx_cnt_ff;
  logic tx_push, tx_pop;
  assign tx_push = wr_tag && tx_cnt_ff != `HLC_FIFO_FULL;
  assign tx_head = tx_mem[tx_rp_ff];

  // storage; a full fifo takes no more bytes
  always_ff @(posedge clk) begin
    if (tx_push) tx_mem[tx_wp_ff] <= '{last: reg_wdata[0], data: txdat_ff};
  end

  // pointers and level
  always_ff @(posedge clk) begin
    if (rst || tx_flush) begin
      tx_wp_ff <= 8'h00;
      tx_rp_ff <= 8'h00;
      tx_cnt_ff <= 9'h000;
    end else begin
      if (tx_push) tx_wp_ff <= tx_wp_ff + 8'h01;
      if (tx_pop) tx_rp_ff <= tx_rp_ff + 8'h01;
      tx_cnt_ff <= tx_cnt_ff + {8'h00, tx_push} - {8'h00, tx_pop};
    end
  end

  // ==========================================
  // transmit serializer
  hlc_pkg::hlc_tx_e tx_st_ff, nxt_tx_st;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic [2:0] tx_bc_ff, tx_ones_ff;
  logic [15:0] crc_ff, crc_nx, fcs;
  logic tx_last_ff, nxt_tx_last, tx_bit_ff;
  logic tx_stf, tx_ins0, tx_cur, tx_end, tx_eom, tx_udr;
  logic [7:0] fill_byte;
  assign fill_byte = ctrl1_ff[`HLC_B_FILL] ? `HLC_IDLE : `HLC_FLAG;
  assign tx_stf = !ctrl1_ff[`HLC_B_STF_DEF] && (tx_st_ff == hlc_pkg::TX_DATA ||
    tx_st_ff == hlc_pkg::TX_CRC_LO || tx_st_ff == hlc_pkg::TX_CRC_HI);
  assign tx_ins0 = !ctrl1_ff[`HLC_B_STF_DEF] && tx_ones_ff == 3'h5; // also before closing flag
  assign tx_cur = tx_ins0 ? 1'b0 : tx_sh_ff[0];
  assign tx_end = tx_bit_req && !tx_ins0 && tx_bc_ff == 3'h7;
  assign fcs = ctrl1_ff[`HLC_B_CRC_INV] ? crc_nx : ~crc_nx;
  assign tx_bit = tx_bit_ff;

  // running check sequence over data bits only
  always_comb begin
    crc_nx = crc_ff;
    if (tx_bit_req && !tx_ins0 && tx_st_ff == hlc_pkg::TX_DATA) begin
      crc_nx = {1'b0, crc_ff[15:1]} ^ ((crc_ff[0] ^ tx_sh_ff[0]) ? `HLC_CRC_POLY : 16'h0000);
    end
  end

  // choice of the next byte at each byte boundary
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_last = tx_last_ff;
    tx_pop = 1'b0;
    tx_eom = 1'b0;
    tx_udr = 1'b0;
    if (tx_end) begin
      case (tx_st_ff)
        hlc_pkg::TX_FILL, hlc_pkg::TX_ABORT, hlc_pkg::TX_CLOSE2: begin
          if (tx_cnt_ff >= `HLC_START_MIN) begin
            nxt_tx_st = hlc_pkg::TX_OPEN;
            nxt_tx_sh = `HLC_FLAG;
          end else begin
            nxt_tx_st = hlc_pkg::TX_FILL;
            nxt_tx_sh = fill_byte;
          end
        end
        hlc_pkg::TX_OPEN, hlc_pkg::TX_DATA: begin
          if (tx_st_ff == hlc_pkg::TX_DATA && tx_last_ff) begin
            if (ctrl1_ff[`HLC_B_CRC_DEF]) begin
              nxt_tx_st = hlc_pkg::TX_CLOSE;
              nxt_tx_sh = `HLC_FLAG;
            end else begin
              nxt_tx_st = hlc_pkg::TX_CRC_LO;
              nxt_tx_sh = fcs[7:0];
            end
          end else if (tx_cnt_ff == 9'h000) begin
            nxt_tx_st = hlc_pkg::TX_ABORT;
            nxt_tx_sh = `HLC_ABORT;
            tx_udr = 1'b1;
          end else begin
            nxt_tx_st = hlc_pkg::TX_DATA;
            nxt_tx_sh = tx_head.data;
            nxt_tx_last = tx_head.last;
            tx_pop = 1'b1;
            tx_eom = tx_head.last;
          end
        end
        hlc_pkg::TX_CRC_LO: begin
          nxt_tx_st = hlc_pkg::TX_CRC_HI;
          nxt_tx_sh = crc_ff[15:8] ^ (ctrl1_ff[`HLC_B_CRC_INV] ? 8'h00 : 8'hFF);
        end
        hlc_pkg::TX_CRC_HI: begin
          nxt_tx_st = hlc_pkg::TX_CLOSE;
          nxt_tx_sh = `HLC_FLAG;
        end
        hlc_pkg::TX_CLOSE: begin
          nxt_tx_st = hlc_pkg::TX_CLOSE2;
          nxt_tx_sh = `HLC_FLAG;
        end
        default: begin
          nxt_tx_st = hlc_pkg::TX_FILL;
          nxt_tx_sh = fill_byte;
        end
      endcase
    end else if (tx_bit_req && !tx_ins0) begin
      nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
    end
  end

  // serializer state; reset and tx reset start with one abort byte
  always_ff @(posedge clk) begin
    if (rst || tx_flush) begin
      tx_st_ff <= hlc_pkg::TX_ABORT;
      tx_sh_ff <= `HLC_ABORT;
      tx_bc_ff <= 3'h0;
      tx_ones_ff <= 3'h0;
      tx_last_ff <= 1'b0;
      crc_ff <= `HLC_CRC_INIT;
    end else if (tx_bit_req) begin
      tx_st_ff <= nxt_tx_st;
      tx_sh_ff <= nxt_tx_sh;
      tx_last_ff <= nxt_tx_last;
      if (!tx_ins0) tx_bc_ff <= tx_bc_ff + 3'h1;
      tx_ones_ff <= (tx_cur && tx_stf) ? tx_ones_ff + 3'h1 : 3'h0;
      crc_ff <= (nxt_tx_st == hlc_pkg::TX_OPEN) ? `HLC_CRC_INIT : crc_nx;
    end
  end

  // serial output with optional inversion
  always_ff @(posedge clk) begin
    if (rst) tx_bit_ff <= 1'b1;
    else if (tx_bit_req) tx_bit_ff <= tx_cur ^ ctrl1_ff[`HLC_B_TX_INV];
  end

  // ==========================================
  // receive fifo
  hlc_pkg::hlc_rxent_s rx_mem [0:255];
  hlc_pkg::hlc_rxent_s rx_head, rx_in;
  logic [7:0] rx_wp_ff, rx_rp_ff;
  logic [8:0] rx_cnt_ff;
  logic rx_push, rx_want, rx_pop, ovr_blk_ff;
  assign rx_pop = rd_sta && rx_cnt_ff != 9'h000;
  assign rx_push = rx_want && !ovr_blk_ff && rx_cnt_ff != `HLC_FIFO_FULL;
  assign rx_head = rx_mem[rx_rp_ff];

  // storage
  always_ff @(posedge clk) begin
    if (rx_push) rx_mem[rx_wp_ff] <= rx_in;
  end

  // pointers, level and overrun block until emptied
  always_ff @(posedge clk) begin
    if (rst || rx_flush) begin
      rx_wp_ff <= 8'h00;
      rx_rp_ff <= 8'h00;
      rx_cnt_ff <= 9'h000;
      ovr_blk_ff <= 1'b0;
    end else begin
      if (rx_push) rx_wp_ff <= rx_wp_ff + 8'h01;
      if (rx_pop) rx_rp_ff <= rx_rp_ff + 8'h01;
      rx_cnt_ff <= rx_cnt_ff + {8'h00, rx_push} - {8'h00, rx_pop};
      if (rx_want && rx_cnt_ff == `HLC_FIFO_FULL) ovr_blk_ff <= 1'b1;
      else if (rx_cnt_ff == 9'h000) ovr_blk_ff <= 1'b0;
    end
  end

  // ==========================================
  // receive deframer
  hlc_pkg::hlc_rx_e rx_st_ff;
  logic [7:0] win_ff, rsh_ff, pend_ff, rsh_nx;
  logic [2:0] rx_ones_ff, rbc_ff;
  logic pend_vld_ff, pend_first_ff;
  logic rb, rflag, rabort, rstuffed, rbyte, ev_rabt, ev_rps, ev_rpe;
  assign rb = rx_bit ^ ctrl1_ff[`HLC_B_RX_INV];
  assign rflag = {rb, win_ff[7:1]} == `HLC_FLAG;
  assign rabort = rb && rx_ones_ff == 3'h6;
  assign rstuffed = !rb && rx_ones_ff == 3'h5;
  assign rsh_nx = {rb, rsh_ff[7:1]};
  assign rbyte = rx_bit_valid && rx_st_ff != hlc_pkg::RX_HUNT && !rflag &&
    !rabort && !rstuffed && rbc_ff == 3'h7;
  assign ev_rabt = rx_bit_valid && rabort && rx_st_ff == hlc_pkg::RX_PKT;
  assign ev_rps = rbyte && rx_st_ff == hlc_pkg::RX_FLAGGED;
  assign ev_rpe = rx_bit_valid && rflag && rx_st_ff == hlc_pkg::RX_PKT;

  // a byte goes to the fifo once the next byte or the closing flag shows
  always_comb begin
    rx_want = pend_vld_ff && (rbyte || ev_rpe);
    rx_in = '{last: ev_rpe, first: pend_first_ff, data: pend_ff};
  end

  // bit level framing, destuffing and byte alignment
  always_ff @(posedge clk) begin
    if (rst || rx_flush) begin
      rx_st_ff <= hlc_pkg::RX_HUNT;
      win_ff <= 8'h00;
      rsh_ff <= 8'h00;
      pend_ff <= 8'h00;
      rx_ones_ff <= 3'h0;
      rbc_ff <= 3'h0;
      pend_vld_ff <= 1'b0;
      pend_first_ff <= 1'b0;
    end else if (rx_bit_valid) begin
      win_ff <= {rb, win_ff[7:1]};
      rx_ones_ff <= rb ? (rx_ones_ff == 3'h7 ? 3'h7 : rx_ones_ff + 3'h1) : 3'h0;
      if (rflag) begin
        rx_st_ff <= hlc_pkg::RX_FLAGGED;
        rbc_ff <= 3'h0;
        pend_vld_ff <= 1'b0;
      end else if (rabort) begin
        rx_st_ff <= hlc_pkg::RX_HUNT;
        pend_vld_ff <= 1'b0;
      end else if (rx_st_ff != hlc_pkg::RX_HUNT && !rstuffed) begin
        rsh_ff <= rsh_nx;
        rbc_ff <= rbc_ff + 3'h1;
        if (rbyte) begin
          rx_st_ff <= hlc_pkg::RX_PKT;
          pend_ff <= rsh_nx;
          pend_vld_ff <= 1'b1;
          pend_first_ff <= rx_st_ff == hlc_pkg::RX_FLAGGED;
        end
      end
    end
  end

  // ==========================================
  // watermarks and latched status
  assign tx_thr = {1'b0, wmark_ff[`HLC_B_TLM_LO +: 3], `HLC_WM_SHIFT'(0)};
  assign rx_thr = {1'b0, wmark_ff[`HLC_B_RHM_LO +: 3], `HLC_WM_SHIFT'(0)};
  assign tx_low = tx_cnt_ff < tx_thr;
  assign rx_high = rx_cnt_ff > rx_thr;

  // event sources of the latched flags
  always_comb begin
    lat_set = 8'h00;
    lat_set[`HLC_L_TEND] = tx_bit_req && (tx_eom || tx_udr);
    lat_set[`HLC_L_TUDR] = tx_bit_req && tx_udr;
    lat_set[`HLC_L_TX_LOW_MARK_LIVE] = tx_low && !tlm_old_ff;
    lat_set[`HLC_L_RX_HIGH_MARK_LIVE] = rx_high && !rhm_old_ff;
    lat_set[`HLC_L_RABT] = ev_rabt;
    lat_set[`HLC_L_RPS] = ev_rps;
    lat_set[`HLC_L_RPE] = ev_rpe;
    lat_set[`HLC_L_ROVR] = rx_want && !ovr_blk_ff && rx_cnt_ff == `HLC_FIFO_FULL;
    nxt_latch = (latch_ff & ~(wr_lat ? reg_wdata : 8'h00)) | lat_set;
  end

  // latched flags, a new event wins over a clear
  always_ff @(posedge clk) begin
    if (rst) latch_ff <= 8'h00;
    else latch_ff <= nxt_latch;
  end

  // interrupt output
  always_ff @(posedge clk) begin
    if (rst) irq_ff <= 1'b0;
    else irq_ff <= link_block_irq_en && |(latch_ff & ien_ff);
  end
  assign irq = irq_ff;

  // ==========================================
  // register read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `HLC_OFS_CTRL1: rdata_ff <= ctrl1_ff;
        `HLC_OFS_WMARK: rdata_ff <= wmark_ff;
        `HLC_OFS_LIVE: rdata_ff <= {4'h0, rx_high, tx_low, 2'b00};
        `HLC_OFS_LATCH: rdata_ff <= latch_ff;
        `HLC_OFS_IEN: rdata_ff <= ien_ff;
        `HLC_OFS_TXDAT: rdata_ff <= txdat_ff;
        `HLC_OFS_RXDAT: rdata_ff <= rx_head.data;
        `HLC_OFS_RXSTA: rdata_ff <= {6'h00, rx_head.last, rx_head.first};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign reg_rdata = rdata_ff;
endmodule

// *** verif/hlc_ctrl_sva.sv ***
`timescale 1ns/1ps
module hlc_ctrl_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // interrupt
  input wire logic link_block_irq_en,
  input wire logic irq,
  // serial link
  input wire logic tx_bit_req,
  input wire logic tx_bit,
  input wire logic rx_bit_valid,
  input wire logic rx_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // shadows of enables, watermark select and flags seen set
  logic [7:0] ien_ff, wm_ff, seen_ff, wclr;
  logic rd3_ff;
  assign wclr = (reg_wr && reg_addr == 4'h3) ? reg_wdata : 8'h00;
  always_ff @(posedge clk) begin
    if (rst) begin
      ien_ff <= 8'h00;
      wm_ff <= 8'h00;
      seen_ff <= 8'h00;
      rd3_ff <= 1'b0;
    end else begin
      rd3_ff <= reg_rd && reg_addr == 4'h3;
      if (reg_wr && reg_addr == 4'h4) ien_ff <= reg_wdata;
      if (reg_wr && reg_addr == 4'h1) wm_ff <= reg_wdata;
      seen_ff <= (rd3_ff ? reg_rdata : seen_ff) & ~wclr;
    end
  end
  // ==========
  // checks
  a_flag_sticky:
    assert property (rd3_ff |-> (reg_rdata & seen_ff) == seen_ff) else $error("flag lost");
  a_irq_block_off:
    assert property (!$past(link_block_irq_en) |-> !irq) else $error("irq while block off");
  a_irq_ien_off:
    assert property ($past(ien_ff) == 8'h00 |-> !irq) else $error("irq with no enable");
  a_ctrl_readback:
    assert property ((reg_wr && reg_addr == 4'h0) ##1 (reg_rd && reg_addr == 4'h0)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("control readback");
  a_wmark_readback:
    assert property ((reg_wr && reg_addr == 4'h1) ##1 (reg_rd && reg_addr == 4'h1)
      |=> (reg_rdata & 8'h77) == ($past(reg_wdata, 2) & 8'h77)) else $error("wmark readback");
  a_ien_readback:
    assert property ((reg_wr && reg_addr == 4'h4) ##1 (reg_rd && reg_addr == 4'h4)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("enable readback");
  a_tx_low_zero:
    assert property (reg_rd && reg_addr == 4'h2 && wm_ff[2:0] == 3'h0
      && $past(wm_ff[2:0]) == 3'h0 |=> !reg_rdata[2]) else $error("low mark at zero");
  a_tx_bit_holds:
    assert property (!$past(tx_bit_req) |-> $stable(tx_bit)) else $error("tx bit moved");
endmodule
bind hlc_ctrl hlc_ctrl_sva chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .link_block_irq_en(link_block_irq_en), .irq(irq), .tx_bit_req(tx_bit_req),
  .tx_bit(tx_bit), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

// *** verif/hlc_framer_model.sv ***
`timescale 1ns/1ps
module hlc_framer_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pacing: a request every other cycle
  input wire logic slow,
  // overhead insertion side
  output logic tx_bit_req,
  input wire logic tx_bit,
  // overhead extraction side
  output logic rx_bit_valid,
  output logic rx_bit
);
  logic tx_q[$];
  logic rx_q[$];
  logic req_d;
  initial begin
    tx_bit_req = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
  end
  // ==========
  // transmit: take each bit in the cycle after its request
  always @(posedge clk) begin
    if (rst) begin
      tx_bit_req <= 1'b0;
      req_d <= 1'b0;
      tx_q.delete();
    end else begin
      tx_bit_req <= slow ? !tx_bit_req : 1'b1;
      req_d <= tx_bit_req;
      if (req_d) tx_q.push_back(tx_bit);
    end
  end
  // receive: one queued bit a cycle, line toggles while nothing is sent
  always @(posedge clk) begin
    if (rst || rx_q.size() == 0) begin
      rx_bit_valid <= 1'b0;
      rx_bit <= !rx_bit;
    end else begin
      rx_bit_valid <= 1'b1;
      rx_bit <= rx_q.pop_front();
    end
  end
endmodule

// *** verif/hlc_ctrl_test.sv ***
`timescale 1ns/1ps
`include "hlc_defs.svh"
module hlc_ctrl_test;
  logic clk, rst, reg_wr, reg_rd, link_block_irq_en, irq;
  logic tx_bit_req, tx_bit, rx_bit_valid, rx_bit, slow, rinv, s;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] c;
  logic exp_q[$];
  logic [15:0] fills[4] = '{16'h007E, 16'h08FF, 16'h1081, 16'h1800};
  logic [7:0] pcfg[4] = '{8'h00, 8'h02, 8'h01, 8'h04};
  int num_errors, tests_run, ones, m;
  // ==========
  // design and far-side model
  hlc_ctrl uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_block_irq_en(link_block_irq_en), .irq(irq), .tx_bit_req(tx_bit_req),
    .tx_bit(tx_bit), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));
  hlc_framer_model fm (.clk(clk), .rst(rst), .slow(slow), .tx_bit_req(tx_bit_req),
    .tx_bit(tx_bit), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    tests_run++;
    if (got !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // write then read back in the very next cycle
  task automatic wrrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    @(posedge clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] msk, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & msk, e);
    @(posedge clk);
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, irq}, {7'h00, e});
    @(posedge clk);
  endtask
  // expected line bits, lsb first, zero after five ones when stuffing
  task automatic put(input logic [7:0] b, input logic stf);
    for (int i = 0; i < 8; i++) begin
      exp_q.push_back(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (stf && ones == 5) begin
        exp_q.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  function automatic logic has_seq(int from);
    for (int i = from; i + exp_q.size() <= fm.tx_q.size(); i++) begin
      int k;
      k = 0;
      while (k < exp_q.size() && fm.tx_q[i + k] === exp_q[k]) k++;
      if (k == exp_q.size()) return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic wait_seq(input int from);
    int n;
    n = 0;
    while (!has_seq(from) && n < 600) begin
      @(posedge clk);
      n++;
    end
    n = has_seq(from) ? 0 : 600;
    chk({7'h00, n == 0}, 8'h01);
    exp_q.delete();
    if (n != 0) wrap_up();
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) fm.rx_q.push_back(b[i] ^ rinv);
  endtask
  task automatic drain;
    for (int n = 0; n < 2500 && fm.rx_q.size() > 0; n++) @(posedge clk);
    if (fm.rx_q.size() > 0) begin
      chk(8'h00, 8'h01);
      wrap_up();
    end
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [15:0] crc(logic [15:0] r, logic [7:0] b);
    for (int i = 0; i < 8; i++) r = (r[0] ^ b[i]) ? (r >> 1) ^ `HLC_CRC_POLY : r >> 1;
    return r;
  endfunction
  // ==========
  // main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    link_block_irq_en = 1'b0;
    slow = 1'b0;
    rinv = 1'b0;
    num_errors = 0;
    tests_run = 0;
    ones = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(4'h0, 8'hFF, `HLC_RST_CTRL1);
    rc(4'h1, 8'hFF, `HLC_RST_WMARK);
    rc(4'h4, 8'hFF, `HLC_RST_IEN);
    wrrd(4'h4, 8'hA5, 8'hA5);
    wr(4'h4, 8'h00);
    wrrd(4'h0, 8'h27, 8'h27);
    wrrd(4'h0, 8'h00, 8'h00);
    wrrd(4'h1, 8'h70, 8'h70);
    wrrd(4'h1, 8'h00, 8'h00);
    put(`HLC_ABORT, 0);
    put(`HLC_FLAG, 0);
    wait_seq(0);
    // fill byte kind and line inversion
    foreach (fills[i]) begin
      m = fm.tx_q.size();
      wr(4'h0, fills[i][15:8]);
      repeat (3) put(fills[i][7:0], 0);
      wait_seq(m);
    end
    // transmit reset sends one abort then fill
    m = fm.tx_q.size();
    wr(4'h0, 8'h40);
    put(`HLC_ABORT, 0);
    put(`HLC_FLAG, 0);
    wait_seq(m);
    wr(4'h0, 8'h00);
    // packets under each check sequence and stuffing option
    foreach (pcfg[i]) begin
      slow <= (i == 3);
      wr(4'h0, pcfg[i]);
      m = fm.tx_q.size();
      wr(4'h5, 8'hFF);
      wr(4'h6, 8'h00);
      wr(4'h5, 8'h3C);
      wr(4'h6, 8'h01);
      c = crc(crc(`HLC_CRC_INIT, 8'hFF), 8'h3C);
      if (!pcfg[i][1]) c = ~c;
      s = !pcfg[i][2];
      put(`HLC_FLAG, 0);
      put(8'hFF, s);
      put(8'h3C, s);
      if (!pcfg[i][0]) begin
        put(c[7:0], s);
        put(c[15:8], s);
      end
      put(`HLC_FLAG, 0);
      put(`HLC_FLAG, 0);
      wait_seq(m);
      rc(4'h3, 8'h01, 8'h01);
      wr(4'h3, 8'h01);
      rc(4'h3, 8'h01, 8'h00);
    end
    slow <= 1'b0;
    // underrun: message ends without a tag
    m = fm.tx_q.size();
    wr(4'h5, 8'h11);
    wr(4'h6, 8'h00);
    wr(4'h5, 8'h22);
    wr(4'h6, 8'h00);
    put(`HLC_FLAG, 0);
    put(8'h11, 1);
    put(8'h22, 1);
    put(`HLC_ABORT, 0);
    wait_seq(m);
    rc(4'h3, 8'h03, 8'h03);
    // interrupt gating by flag, own enable and block enable
    link_block_irq_en <= 1'b1;
    wr(4'h4, 8'h02);
    irqchk(1'b1);
    link_block_irq_en <= 1'b0;
    irqchk(1'b0);
    link_block_irq_en <= 1'b1;
    wr(4'h4, 8'hFC);
    irqchk(1'b0);
    wr(4'h4, 8'h02);
    wr(4'h3, 8'h02);
    irqchk(1'b0);
    wr(4'h0, 8'h40);
    wr(4'h0, 8'h00);
    // transmit low watermark rises with an empty fifo
    wr(4'h1, 8'h01);
    rc(4'h2, 8'h04, 8'h04);
    rc(4'h3, 8'h04, 8'h04);
    wr(4'h3, 8'h04);
    rc(4'h3, 8'h04, 8'h00);
    // receive packet, fifo tags, high watermark
    wr(4'h1, 8'h00);
    wr(4'h3, 8'hFF);
    send(`HLC_FLAG);
    send(8'h55);
    send(8'hAA);
    send(`HLC_FLAG);
    drain();
    rc(4'h3, 8'h68, 8'h68);
    rc(4'h2, 8'h08, 8'h08);
    rc(4'h7, 8'hFF, 8'h55);
    rc(4'h8, 8'h03, 8'h01);
    rc(4'h7, 8'hFF, 8'hAA);
    rc(4'h8, 8'h03, 8'h02);
    rc(4'h2, 8'h08, 8'h00);
    send(`HLC_FLAG);
    send(8'h55);
    send(`HLC_FLAG);
    drain();
    rc(4'h2, 8'h08, 8'h08);
    wr(4'h0, 8'h80);
    wr(4'h0, 8'h00);
    rc(4'h2, 8'h08, 8'h00);
    // abort inside and outside a packet
    wr(4'h3, 8'hFF);
    send(`HLC_FLAG);
    send(8'h55);
    send(8'hFF);
    drain();
    rc(4'h3, 8'h10, 8'h10);
    wr(4'h3, 8'hFF);
    send(8'hFF);
    send(8'hFF);
    drain();
    rc(4'h3, 8'h10, 8'h00);
    // inverted receive line
    wr(4'h0, 8'h20);
    rinv = 1'b1;
    wr(4'h3, 8'hFF);
    send(`HLC_FLAG);
    send(8'h55);
    send(`HLC_FLAG);
    drain();
    rc(4'h3, 8'h60, 8'h60);
    // receive overrun, then no second flag while the fifo stays full
    wr(4'h0, 8'hA0);
    wr(4'h0, 8'h20);
    wr(4'h3, 8'hFF);
    send(`HLC_FLAG);
    repeat (258) send(8'h55);
    send(`HLC_FLAG);
    drain();
    rc(4'h3, 8'h80, 8'h80);
    wr(4'h3, 8'h80);
    send(`HLC_FLAG);
    send(8'h55);
    send(8'h55);
    send(`HLC_FLAG);
    drain();
    rc(4'h3, 8'h80, 8'h00);
    wrap_up();
  end
endmodule
